// File: pei_mgmt_master.sv
// management controller model that frames register reads and writes on mdc/mdio
`timescale 1ns/1ps
`default_nettype none

module pei_mgmt_master (
   input  wire logic mclk,
   output logic      mdc,
   output logic      mdio_m,
   output logic      mdio_m_oe,
   input  wire logic mdio_w
);
   import pei_pkg::*;

   // mdc rests low between frames, data line left to the pull-up
   initial begin
      mdc       = 1'b0;
      mdio_m    = 1'b0;
      mdio_m_oe = 1'b0;
   end

   // full frame: 32 ones, start, op, phy, reg, turnaround, 16 data bits
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] fr;
      fr = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 0; i < 64; i++) begin
         @(negedge mclk);
         mdio_m    <= fr[63-i];
         mdio_m_oe <= (op == OP_WRITE) || (i < 46); // reads let go from the turnaround
         // device answer lands ~4 mclk after a rise, so sample just before the next
         repeat (8) @(negedge mclk);
         if (i >= 48) begin
            rd = {rd[14:0], mdio_w};
         end
         mdc <= 1'b1;
         repeat (8) @(negedge mclk);
         mdc <= 1'b0;
      end
      @(negedge mclk);
      mdio_m_oe <= 1'b0;
   endtask

endmodule // pei_mgmt_master

`default_nettype wire

// File: pei_phy_event_irq.sv
// phy event interrupt unit with its management serial register slave
// Functional notes
// R1: events: link quality, energy detect, link, speed, duplex, autoneg done, counter half-full.
// R2: control bits 15:3 ignore writes and read zero.
// R3: test interrupt bit 2 forces the interrupt while set.
// R4: master enable bit 1 gates all event based interrupts.
// R5: bit 0 makes the shared pin an irq output, else powerdown input.
// R6: a status bit sets if its event happened since the last status read.
// R7: status bits set even with event or master enable off.
// R8: an event interrupts only with its own enable and master enable set.
// R9: status bit 15 is link quality pending, cleared by the read returning it.
// R10: status bit 14 is energy detect pending, cleared by its read.
// R11: status bit 13 is link change pending, cleared by its read.
// R12: status bit 12 is speed change pending, cleared by its read.
// R13: status bit 11 is duplex change pending, cleared by its read.
// R14: status bit 10 is autoneg done pending, cleared by its read.
// R15: status bit 9 is false carrier counter half-full, cleared by its read.
// R16: status bit 8 is receive error counter half-full, cleared by its read.
// R17: bits 7:0 are per-event enables in status order, reset zero.
// R18: both event counters are eight bits and saturate at maximum.
// R19: half-full event is counter msb rising, once per crossing.
// R20: as irq output, pin is low while test or enabled pending under master.
`timescale 1ns/1ps
`default_nettype none

module pei_phy_event_irq
   import pei_pkg::*;
(
   input  wire  logic                 mclk,
   input  wire  logic                 rst,
   input  wire  logic                 ce,
   input  wire  logic [4:0]           phy_addr,
   input  wire  pei_pkg::pei_events_t events,
   input  wire  logic                 mdc,
   input  wire  logic                 mdio_i,
   output logic                       mdio_o,
   output logic                       mdio_oe,
   input  wire  logic                 pin_i,
   output logic                       irq_pin_o,
   output logic                       irq_pin_oe,
   output logic                       powerdown_req
);
   import pei_pkg::*;

   typedef struct packed {
      logic [SY_W-1:0]    sync1;
      logic [SY_W-1:0]    sync2;
      logic [SY_W-1:0]    sync3;
      logic [SY_W-1:0]    lvl;
      pei_mgmt_state_t    mstate;
      logic [5:0]         ones;
      logic [4:0]         bitcnt;
      logic [11:0]        hdr;
      logic [15:0]        shreg;
      logic [CTRL_W-1:0]  ctrl;
      logic [EV_W-1:0]    pending;
      logic [EV_W-1:0]    enable;
      logic [CNT_W-1:0]   fc_cnt;
      logic [CNT_W-1:0]   rxe_cnt;
      pei_pins_t          pins;
   } pei_state_t;

   pei_state_t st;
   pei_state_t next_st;

   logic             mdc_rise;
   logic             bit_in;
   logic [EV_W-1:0]  ev_vec;
   logic [EV_W-1:0]  clr_pend;
   logic             clr_fc;
   logic             clr_rxe;
   logic             fc_half;
   logic             rxe_half;
   logic             addr_hit;
   logic [15:0]      wr_word;

   // register read image; reserved bits come back as zero
   function automatic logic [15:0] read_word(input logic [4:0]        ra,
                                             input logic [CTRL_W-1:0] c,
                                             input logic [EV_W-1:0]   p,
                                             input logic [EV_W-1:0]   e,
                                             input logic [CNT_W-1:0]  f,
                                             input logic [CNT_W-1:0]  r);
      logic [15:0] w;
      w = 16'h0000;
      if (ra == REG_CTRL) begin
         w[CTRL_W-1:0] = c;                     // R2
      end else if (ra == REG_STAT) begin
         w = {p, e};
      end else if (ra == REG_FC_COUNT) begin
         w[CNT_W-1:0] = f;
      end else if (ra == REG_RXE_COUNT) begin
         w[CNT_W-1:0] = r;
      end
      return w;
   endfunction

   // saturating counter step, clear wins only over the old count
   function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c,
                                                 input logic             clr,
                                                 input logic             inc);
      logic [CNT_W-1:0] b;
      b = clr ? '0 : c;
      if (inc && b != CNT_MAX) begin
         b = b + CNT_ONE;                       // R18
      end
      return b;
   endfunction

   // whole next state: synchronisers, management fsm, counters, status, pins
   always_comb begin
      next_st  = st;
      clr_pend = '0;
      clr_fc   = 1'b0;
      clr_rxe  = 1'b0;
      wr_word  = {st.shreg[14:0], 1'b0};

      // three-stage sync; a change counts once stages two and three agree
      next_st.sync1 = {pin_i, mdio_i, mdc};
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      for (int i = 0; i < SY_W; i++) begin
         if (st.sync2[i] == st.sync3[i]) begin
            next_st.lvl[i] = st.sync3[i];
         end
      end
      // mdio shares the same latency as mdc, so the sample lines up
      mdc_rise = next_st.lvl[SY_MDC] & ~st.lvl[SY_MDC];
      bit_in   = next_st.lvl[SY_MDIO];
      wr_word  = {st.shreg[14:0], bit_in};
      addr_hit = (st.hdr[9:5] == phy_addr);

      if (mdc_rise) begin
         unique case (st.mstate)
            MS_PRE: begin
               if (bit_in) begin
                  if (st.ones != PREAMBLE_ONES) begin
                     next_st.ones = st.ones + 6'h01;
                  end
               end else if (st.ones == PREAMBLE_ONES) begin
                  next_st.mstate = MS_START;
               end else begin
                  next_st.ones = '0;
               end
            end
            MS_START: begin
               next_st.ones   = '0;
               next_st.bitcnt = '0;
               next_st.mstate = bit_in ? MS_HDR : MS_PRE;
            end
            MS_HDR: begin
               next_st.hdr    = {st.hdr[10:0], bit_in};
               next_st.bitcnt = st.bitcnt + 5'h01;
               if (st.bitcnt == HDR_LAST) begin
                  next_st.bitcnt = '0;
                  next_st.mstate = MS_TA;
               end
            end
            MS_TA: begin
               if (st.hdr[11:10] == OP_READ && addr_hit) begin
                  // first ta bit: take the line and drive the zero
                  next_st.pins.mdio_oe = 1'b1;
                  next_st.pins.mdio_o  = 1'b0;
                  next_st.shreg  = read_word(st.hdr[4:0], st.ctrl, st.pending,
                                             st.enable, st.fc_cnt, st.rxe_cnt);
                  next_st.mstate = MS_RDATA;
                  if (st.hdr[4:0] == REG_STAT) begin
                     clr_pend = st.pending;     // R9 R10 R11 R12 R13 R14 R15 R16
                  end
                  clr_fc  = (st.hdr[4:0] == REG_FC_COUNT);
                  clr_rxe = (st.hdr[4:0] == REG_RXE_COUNT);
               end else if (st.hdr[11:10] == OP_WRITE && addr_hit) begin
                  next_st.bitcnt = st.bitcnt + 5'h01;
                  if (st.bitcnt == TA_LAST) begin
                     next_st.bitcnt = '0;
                     next_st.mstate = MS_WDATA;
                  end
               end else begin
                  // other address or bad opcode: wait for a fresh preamble
                  next_st.mstate = MS_PRE;
               end
            end
            MS_RDATA: begin
               if (st.bitcnt == DATA_BITS) begin
                  next_st.pins.mdio_oe = 1'b0;
                  next_st.pins.mdio_o  = 1'b0;
                  next_st.bitcnt       = '0;
                  next_st.mstate       = MS_PRE;
               end else begin
                  next_st.pins.mdio_o = st.shreg[15];
                  next_st.shreg       = {st.shreg[14:0], 1'b0};
                  next_st.bitcnt      = st.bitcnt + 5'h01;
               end
            end
            MS_WDATA: begin
               next_st.shreg  = wr_word;
               next_st.bitcnt = st.bitcnt + 5'h01;
               if (st.bitcnt == WDATA_LAST) begin
                  next_st.bitcnt = '0;
                  next_st.mstate = MS_PRE;
                  if (st.hdr[4:0] == REG_CTRL) begin
                     next_st.ctrl = wr_word[CTRL_W-1:0];      // R2
                  end else if (st.hdr[4:0] == REG_STAT) begin
                     next_st.enable = wr_word[EV_W-1:0];      // R17
                  end
               end
            end
            default: begin
               next_st.mstate = MS_PRE;
               next_st.ones   = '0;
            end
         endcase
      end

      // counters; a read clear in the same cycle as a hit keeps the hit
      next_st.fc_cnt  = cnt_step(st.fc_cnt, clr_fc, events.false_carrier_inc);
      next_st.rxe_cnt = cnt_step(st.rxe_cnt, clr_rxe, events.rx_error_inc);
      fc_half  = next_st.fc_cnt[CNT_MSB] & ~st.fc_cnt[CNT_MSB];      // R19
      rxe_half = next_st.rxe_cnt[CNT_MSB] & ~st.rxe_cnt[CNT_MSB];    // R19

      // status latches regardless of enables; set beats read clear
      ev_vec = {events.link_quality, events.energy_detect, events.link_change,
                events.speed_change, events.duplex_change, events.autoneg_done,
                fc_half, rxe_half};                                   // R1
      next_st.pending = (st.pending & ~clr_pend) | ev_vec;            // R6 R7

      // shared pin: active low irq, or a powerdown request input
      next_st.pins.irq_pin_oe = st.ctrl[CTRL_PIN_OE];                 // R5
      next_st.pins.irq_pin_o  = ~(st.ctrl[CTRL_TEST] |                // R3
                                  (st.ctrl[CTRL_MASTER] &             // R4
                                   (|(st.pending & st.enable))));     // R8 R20
      next_st.pins.powerdown_req = ~st.ctrl[CTRL_PIN_OE] & ~st.lvl[SY_PIN];
   end

   // state register; ce low freezes everything
   always_ff @(posedge mclk) begin
      if (rst) begin
         st                <= '0;
         st.sync1          <= SY_IDLE;
         st.sync2          <= SY_IDLE;
         st.sync3          <= SY_IDLE;
         st.lvl            <= SY_IDLE;
         st.mstate         <= MS_PRE;
         st.ctrl           <= CTRL_RESET;
         st.enable         <= EN_RESET;                  // R17
         st.pending        <= PEND_RESET;
         st.pins.irq_pin_o <= 1'b1;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // outputs straight from state flops
   assign mdio_o        = st.pins.mdio_o;
   assign mdio_oe       = st.pins.mdio_oe;
   assign irq_pin_o     = st.pins.irq_pin_o;
   assign irq_pin_oe    = st.pins.irq_pin_oe;
   assign powerdown_req = st.pins.powerdown_req;

   // checks on the control and status registers, counters and the shared pin
   property p_status_sticky;
      @(posedge mclk) disable iff (rst)
      ce && (|ev_vec) |=> ((st.pending & $past(ev_vec)) == $past(ev_vec));
   endproperty
   a_status_sticky: assert property (p_status_sticky)       // R6
      else $error("event did not set its status bit");

   property p_status_ignores_enable;
      @(posedge mclk) disable iff (rst)
      ce && events.link_change && !st.ctrl[CTRL_MASTER] |=> st.pending[5];
   endproperty
   a_status_ignores_enable: assert property (p_status_ignores_enable) // R7
      else $error("status not set with master enable off");

   property p_ctrl_read_zero;
      @(posedge mclk) disable iff (rst)
      ce && mdc_rise && st.mstate == MS_TA && st.hdr[11:10] == OP_READ
         && addr_hit && st.hdr[4:0] == REG_CTRL
         |=> st.shreg[15:CTRL_W] == '0 && st.shreg[CTRL_W-1:0] == $past(st.ctrl);
   endproperty
   a_ctrl_read_zero: assert property (p_ctrl_read_zero)     // R2
      else $error("control read image wrong");

   property p_status_cor;
      @(posedge mclk) disable iff (rst)
      ce && mdc_rise && st.mstate == MS_TA && st.hdr[11:10] == OP_READ
         && addr_hit && st.hdr[4:0] == REG_STAT && !(|ev_vec)
         |=> st.pending == '0 && st.shreg[15:8] == $past(st.pending);
   endproperty
   a_status_cor: assert property (p_status_cor)             // R9
      else $error("status read did not return and clear pending bits");

   property p_test_irq;
      @(posedge mclk) disable iff (rst)
      ce && st.ctrl[CTRL_TEST] && st.ctrl[CTRL_PIN_OE]
         |=> !irq_pin_o && irq_pin_oe;
   endproperty
   a_test_irq: assert property (p_test_irq)                 // R3
      else $error("test interrupt not driven");

   property p_master_off;
      @(posedge mclk) disable iff (rst)
      ce && !st.ctrl[CTRL_MASTER] && !st.ctrl[CTRL_TEST] |=> irq_pin_o;
   endproperty
   a_master_off: assert property (p_master_off)             // R4
      else $error("interrupt raised with master enable off");

   property p_pin_role;
      @(posedge mclk) disable iff (rst)
      ce ##1 ce |-> irq_pin_oe == $past(st.ctrl[CTRL_PIN_OE])
         && (powerdown_req -> !irq_pin_oe);
   endproperty
   a_pin_role: assert property (p_pin_role)                 // R5
      else $error("shared pin role does not follow control bit 0");

   property p_enabled_irq;
      @(posedge mclk) disable iff (rst)
      ce && st.ctrl[CTRL_MASTER] && (|(st.pending & st.enable)) |=> !irq_pin_o;
   endproperty
   a_enabled_irq: assert property (p_enabled_irq)           // R20
      else $error("enabled pending event did not pull the pin low");

   property p_only_enabled;
      @(posedge mclk) disable iff (rst)
      ce && !st.ctrl[CTRL_TEST] && !(|(st.pending & st.enable)) |=> irq_pin_o;
   endproperty
   a_only_enabled: assert property (p_only_enabled)         // R8
      else $error("interrupt without an enabled pending event");

   property p_counter_saturates;
      @(posedge mclk) disable iff (rst)
      ce && st.fc_cnt == CNT_MAX && !clr_fc |=> st.fc_cnt == CNT_MAX;
   endproperty
   a_counter_saturates: assert property (p_counter_saturates) // R18
      else $error("false carrier counter wrapped");

   property p_half_event;
      @(posedge mclk) disable iff (rst)
      ce && !clr_rxe && events.rx_error_inc && st.rxe_cnt == 8'h7f
         |=> st.pending[0] && st.rxe_cnt[CNT_MSB];
   endproperty
   a_half_event: assert property (p_half_event)             // R19
      else $error("receive error half-full not latched");

   property p_read_frame;
      @(posedge mclk) disable iff (rst)
      ce && mdc_rise && st.mstate == MS_TA && st.hdr[11:10] == OP_READ && addr_hit;
   endproperty
   c_read_frame: cover property (p_read_frame);

   property p_write_frame;
      @(posedge mclk) disable iff (rst)
      ce && mdc_rise && st.mstate == MS_WDATA && st.bitcnt == WDATA_LAST;
   endproperty
   c_write_frame: cover property (p_write_frame);

   property p_event_irq;
      @(posedge mclk) disable iff (rst)
      irq_pin_oe && !irq_pin_o && !st.ctrl[CTRL_TEST];
   endproperty
   c_event_irq: cover property (p_event_irq);

endmodule // pei_phy_event_irq

`default_nettype wire

// File: pei_pkg.sv
// shared constants and carrier types for the phy event interrupt unit
package pei_pkg;

   // management register indices (5-bit register address field)
   localparam logic [4:0]  REG_CTRL       = 5'h11;
   localparam logic [4:0]  REG_STAT       = 5'h12;
   localparam logic [4:0]  REG_FC_COUNT   = 5'h14;
   localparam logic [4:0]  REG_RXE_COUNT  = 5'h15;

   // interrupt_control field positions
   localparam int unsigned CTRL_TEST      = 2;
   localparam int unsigned CTRL_MASTER    = 1;
   localparam int unsigned CTRL_PIN_OE    = 0;
   localparam int unsigned CTRL_W         = 3;
   localparam logic [2:0]  CTRL_RESET     = 3'h0;

   // interrupt_status_and_enables layout: pending in 15:8, enables in 7:0
   localparam int unsigned EV_W           = 8;
   localparam logic [7:0]  EN_RESET       = 8'h00;
   localparam logic [7:0]  PEND_RESET     = 8'h00;

   // event counters
   localparam int unsigned CNT_W          = 8;
   localparam int unsigned CNT_MSB        = 7;
   localparam logic [7:0]  CNT_MAX        = 8'hff;
   localparam logic [7:0]  CNT_ONE        = 8'h01;

   // management frame
   localparam logic [5:0]  PREAMBLE_ONES  = 6'h20;
   localparam logic [1:0]  OP_READ        = 2'h2;
   localparam logic [1:0]  OP_WRITE       = 2'h1;
   localparam logic [4:0]  HDR_LAST       = 5'h0b;
   localparam logic [4:0]  TA_LAST        = 5'h01;
   localparam logic [4:0]  DATA_BITS      = 5'h10;
   localparam logic [4:0]  WDATA_LAST     = 5'h0f;

   // synchroniser lanes and their idle levels
   localparam int unsigned SY_MDC         = 0;
   localparam int unsigned SY_MDIO        = 1;
   localparam int unsigned SY_PIN         = 2;
   localparam int unsigned SY_W           = 3;
   localparam logic [2:0]  SY_IDLE        = 3'h6;

   typedef enum logic [2:0] {
      MS_PRE   = 3'b000,
      MS_START = 3'b001,
      MS_HDR   = 3'b010,
      MS_TA    = 3'b011,
      MS_RDATA = 3'b100,
      MS_WDATA = 3'b101
   } pei_mgmt_state_t;

   // one-cycle event pulses from the phy core, same clock
   typedef struct packed {
      logic link_quality;
      logic energy_detect;
      logic link_change;
      logic speed_change;
      logic duplex_change;
      logic autoneg_done;
      logic false_carrier_inc;
      logic rx_error_inc;
   } pei_events_t;

   // shared pin and management pin drive
   typedef struct packed {
      logic mdio_o;
      logic mdio_oe;
      logic irq_pin_o;
      logic irq_pin_oe;
      logic powerdown_req;
   } pei_pins_t;

endpackage

// File: tb_top.sv
// self-checking bench for the phy event interrupt unit
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
   $display("BAD %s expected %h seen %h", nm, ex, got); end end

module tb_top;
   import pei_pkg::*;
   localparam logic [4:0] MY_PHY = 5'h03;

   logic        mclk, rst, ce, mdc, mdio_m, mdio_m_oe, mdio_w, mdio_o, mdio_oe;
   logic        pin_w, pd_drv, irq_pin_o, irq_pin_oe, powerdown_req;
   logic [4:0]  phy_addr;
   pei_events_t events;
   int          errors, checks;
   logic [7:0]  lf;
   logic [15:0] exp_q[$];
   string       nm_q[$];
   logic [15:0] rd_val;
   event        rd_ev;

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // shared lines resolved from every party's enable, pull-up on mdio
   assign mdio_w = mdio_oe ? mdio_o : (mdio_m_oe ? mdio_m : 1'b1);
   assign pin_w  = irq_pin_oe ? irq_pin_o : pd_drv;

   pei_phy_event_irq u_dut (
      .mclk          (mclk),
      .rst           (rst),
      .ce            (ce),
      .phy_addr      (phy_addr),
      .events        (events),
      .mdc           (mdc),
      .mdio_i        (mdio_w),
      .mdio_o        (mdio_o),
      .mdio_oe       (mdio_oe),
      .pin_i         (pin_w),
      .irq_pin_o     (irq_pin_o),
      .irq_pin_oe    (irq_pin_oe),
      .powerdown_req (powerdown_req)
   );

   pei_mgmt_master u_mgmt (
      .mclk      (mclk),
      .mdc       (mdc),
      .mdio_m    (mdio_m),
      .mdio_m_oe (mdio_m_oe),
      .mdio_w    (mdio_w)
   );

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] x;
      u_mgmt.xfer(OP_WRITE, MY_PHY, ra, d, x);
   endtask

   // expectation noted first, the watcher pairs it with the returned word
   task automatic rd(input string nm, input logic [4:0] ra, input logic [15:0] ex);
      exp_q.push_back(ex);
      nm_q.push_back(nm);
      u_mgmt.xfer(OP_READ, MY_PHY, ra, 16'h0000, rd_val);
      -> rd_ev;
      @(negedge mclk);
   endtask

   // n back-to-back cycles of the event pattern, then settle for the pin
   task automatic pulse(input logic [7:0] ev, input int n);
      repeat (n) begin
         @(negedge mclk);
         events <= pei_events_t'(ev);
      end
      @(negedge mclk);
      events <= '0;
      repeat (3) @(negedge mclk);
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial forever begin : watch
      logic [15:0] e;
      string       n;
      @(rd_ev);
      e = exp_q.pop_front();
      n = nm_q.pop_front();
      `CHK(n, e, rd_val)
   end

   // about 50 frames of 1088 cycles plus event bursts; half as much again as slack
   initial begin
      repeat (85000) @(posedge mclk);
      errors++;
      $display("BAD watchdog expected finish seen hang");
      stop_test();
   end

   initial begin
      logic [7:0] en;
      logic [7:0] ev;
      rst = 1'b1;
      ce = 1'b1;
      phy_addr = MY_PHY;
      events = '0;
      pd_drv = 1'b1;
      lf = 8'h39;
      errors = 0;
      checks = 0;
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      `CHK("pin_oe_rst", 1'b0, irq_pin_oe)
      `CHK("pin_rst", 1'b1, irq_pin_o)
      rd("ctrl_rst", REG_CTRL, 16'h0000);
      rd("stat_rst", REG_STAT, 16'h0000);
      $display("test reset done");

      // reserved control bits and the forced interrupt
      wr(REG_CTRL, 16'hffff);
      rd("ctrl_rsv", REG_CTRL, 16'h0007);
      `CHK("pin_test", 1'b0, irq_pin_o)
      `CHK("pin_oe_on", 1'b1, irq_pin_oe)
      wr(REG_CTRL, 16'h0003);
      `CHK("pin_test_off", 1'b1, irq_pin_o)
      $display("test control done");

      // each direct event latches with its enable off, then clears on read
      for (int i = 0; i < 6; i++) begin
         pulse(8'h80 >> i, 1);
         `CHK("pin_masked", 1'b1, irq_pin_o)
         rd("stat_ev", REG_STAT, 16'h8000 >> i);
         rd("stat_clr", REG_STAT, 16'h0000);
      end
      // ce low freezes everything, so an event offered then is never seen
      ce = 1'b0;
      pulse(8'h20, 1);
      ce = 1'b1;
      rd("stat_frozen", REG_STAT, 16'h0000);
      $display("test status done");

      // counter msb crossing, saturation, one event per crossing
      pulse(8'h03, 127);
      rd("no_half", REG_STAT, 16'h0000);
      pulse(8'h03, 1);
      rd("both_half", REG_STAT, 16'h0300);
      pulse(8'h02, 200);
      rd("half_once", REG_STAT, 16'h0000);
      rd("fc_sat", REG_FC_COUNT, 16'h00ff);
      rd("rxe_cnt", REG_RXE_COUNT, 16'h0080);
      $display("test counters done");

      // random enables and events, master enable toggled each pass
      for (int k = 0; k < 8; k++) begin
         lf = lfsr(lf);
         en = lf;
         lf = lfsr(lf);
         ev = lf & 8'hfc;
         wr(REG_STAT, {8'hff, en});
         wr(REG_CTRL, {14'h0000, k[0], 1'b1});
         pulse(ev, 1);
         `CHK("pin_ev", !(k[0] && (ev & en) != 8'h00), irq_pin_o)
         rd("stat_rnd", REG_STAT, {ev, en});
         `CHK("pin_clr", 1'b1, irq_pin_o)
      end
      $display("test random done");

      // a second reset in mid-run puts every register back to zero
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      `CHK("pin_oe_rst2", 1'b0, irq_pin_oe)
      rd("ctrl_rst2", REG_CTRL, 16'h0000);
      rd("stat_rst2", REG_STAT, 16'h0000);
      $display("test midreset done");

      // shared pin as power down input
      wr(REG_CTRL, 16'h0000);
      pd_drv = 1'b0;
      repeat (8) @(negedge mclk);
      `CHK("pd_req", 1'b1, powerdown_req)
      `CHK("pin_in", 1'b0, irq_pin_oe)
      pd_drv = 1'b1;
      repeat (8) @(negedge mclk);
      `CHK("pd_rel", 1'b0, powerdown_req)
      $display("test powerdown done");
      stop_test();
   end
endmodule // tb_top

`default_nettype wire
